// *** logic/sys_setup_pkg.sv ***
// shared constants and types of the system configuration register bank
package sys_setup_pkg;

  // clock
  localparam int CLK_MHZ = 50;

  // register indices; byte address is four times the index
  localparam logic [7:0] OPTIONS_INDEX       = 8'h38;
  localparam logic [7:0] CONFIGURATION_INDEX = 8'h3f;
  localparam logic [7:0] PULLUP_INDEX        = 8'h2c;
  localparam logic [7:0] WDOG_SERVICE_INDEX  = 8'h3a;
  localparam logic [7:0] STATUS_INDEX        = 8'h3b;

  // system_options_two fields
  localparam int OPT_STROBE_DRIVE = 7;
  localparam int OPT_PORTC_OD     = 6;
  localparam int OPT_STRETCH      = 5;
  localparam int OPT_VISIBILITY   = 4;
  localparam int OPT_LOW_BIT      = 3;
  localparam int OPT_SPI_RATE     = 2;
  localparam int OPT_FAST_SRC     = 1;
  localparam int OPT_BUS_CLK_DIS  = 0;

  // system_configuration fields
  localparam int CFG_ROM_HIGH     = 7;
  localparam int CFG_BUS_HOLD     = 6;
  localparam int CFG_FAST_OUT_EN  = 5;
  localparam int CFG_PULLUP_MSTR  = 4;
  localparam int CFG_SECURITY_OFF = 3;
  localparam int CFG_WDOG_OFF     = 2;
  localparam int CFG_ROM_PRESENT  = 1;
  localparam int CFG_EEPROM_PRES  = 0;

  // status fields
  localparam int STAT_SINGLE_CHIP = 0;
  localparam int STAT_LOADED      = 1;
  localparam int STAT_EXT_BUSY    = 2;
  localparam int STAT_PULLUP_LSB  = 4;

  // reset values
  localparam logic [7:0] OPTIONS_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET  = 8'h00;
  localparam logic [3:0] PULLUP_RESET  = 4'hf;

  // timing
  localparam int WDOG_TIMEOUT_US = 16384;
  localparam int WDOG_CYCLES     = WDOG_TIMEOUT_US * CLK_MHZ;
  localparam int SYNC_STAGES     = 2;

  // external access sequencer
  typedef enum logic [1:0] {
    EXT_IDLE    = 2'b00,
    EXT_FIRST   = 2'b01,
    EXT_LAST    = 2'b10,
    EXT_STRETCH = 2'b11
  } ext_state_type;

  // pins sampled from outside the clock domain
  typedef struct packed {
    logic       single_chip;
    logic       bus_clock;
    logic       oscillator_input_clock;
    logic       quadrupled_clock;
    logic [7:0] setup_strap;
  } pin_in_type;

  // memory map and bus selections
  typedef struct packed {
    logic rom_high_map;
    logic bus_hold_when_internal;
    logic security_off;
    logic rom_present;
    logic eeprom_present;
  } memory_map_type;

  function automatic logic [11:0] reg_addr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

endpackage

// *** logic/pin_sync.sv ***
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 12
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_reg;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_reg <= '0;
      sync_out  <= '0;
    end else begin
      stage_reg <= async_in;
      sync_out  <= stage_reg;
    end
  end

endmodule

// *** logic/system_config_registers.sv ***
// system configuration register bank with apb access
//
// Functional notes
// - strobe drive bit enables push-pull strobe
// - port c open-drain when bit set
// - stretch adds one cycle to external access
// - expanded mode: internal reads visible externally
// - single chip: visibility bit holds clock low
// - spi shifts low bit first when set
// - source bit picks oscillator or quadrupled clock
// - disable bit suppresses bus clock output
// - options register resets to zero
// - rom high map, low only when expanded
// - expanded bus freeze outside external accesses
// - fast clock pin driven only when enabled
// - master pull-up enable gates all pull-ups
// - security off bit disables eeprom security
// - watchdog forces reset on timeout unless off
// - rom present bit maps rom
// - eeprom present bit maps eeprom
// - port pull-up needs own and master enable
`timescale 1ns/1ps
module system_config_registers #(
  parameter int WDOG_CYCLES = sys_setup_pkg::WDOG_CYCLES
) (
  // clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic                             pready,
  output logic      [31:0]                 prdata,
  output logic                             pslverr,
  // pins from outside the domain
  input  wire sys_setup_pkg::pin_in_type   pin_in,
  // core side inputs
  input  wire logic                        load_instruction_strobe,
  input  wire logic [7:0]                  portc_data,
  input  wire logic [7:0]                  portc_dir,
  input  wire logic                        ext_access_start,
  input  wire logic                        internal_read_valid,
  input  wire logic [7:0]                  internal_read_data,
  // strobe pin
  output logic                             mode_strobe_pin_o,
  output logic                             mode_strobe_pin_oe,
  // port c
  output logic      [7:0]                  portc_o,
  output logic      [7:0]                  portc_oe,
  // external bus
  output logic                             ext_access_busy,
  output logic      [7:0]                  ext_data_o,
  output logic                             ext_data_oe,
  output logic                             bus_clock_pin,
  // clocks and peripherals
  output logic                             fast_clock_pin,
  output logic                             fast_clock_oe,
  output logic                             serial_low_bit_first,
  output logic                             spi_rate_select,
  output logic      [3:0]                  port_pullup_en,
  output sys_setup_pkg::memory_map_type    memory_map,
  output logic                             watchdog_reset_req
);

  sys_setup_pkg::pin_in_type    pin_s;
  sys_setup_pkg::ext_state_type ext_state_reg;
  sys_setup_pkg::ext_state_type ext_state_next;
  logic [7:0]  options_reg;
  logic [7:0]  setup_reg;
  logic [3:0]  pullup_reg;
  logic [1:0]  load_wait_reg;
  logic        loaded_reg;
  logic [23:0] wdog_count_reg;
  logic        setup_phase;
  logic        wr_commit;
  logic        hit_opt;
  logic        hit_cfg;
  logic        hit_pull;
  logic        hit_wdog;
  logic        hit_stat;
  logic        single_chip;
  logic [7:0]  read_value;

  pin_sync #(
    .WIDTH($bits(sys_setup_pkg::pin_in_type))
  ) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .async_in(pin_in),
    .sync_out(pin_s)
  );
  assign single_chip = pin_s.single_chip;
  // address decode
  always_comb begin
    hit_opt  = 1'b0;
    hit_cfg  = 1'b0;
    hit_pull = 1'b0;
    hit_wdog = 1'b0;
    hit_stat = 1'b0;
    if (paddr == sys_setup_pkg::reg_addr(sys_setup_pkg::OPTIONS_INDEX)) begin
      hit_opt = 1'b1;
    end else if (paddr == sys_setup_pkg::reg_addr(sys_setup_pkg::CONFIGURATION_INDEX)) begin
      hit_cfg = 1'b1;
    end else if (paddr == sys_setup_pkg::reg_addr(sys_setup_pkg::PULLUP_INDEX)) begin
      hit_pull = 1'b1;
    end else if (paddr == sys_setup_pkg::reg_addr(sys_setup_pkg::WDOG_SERVICE_INDEX)) begin
      hit_wdog = 1'b1;
    end else if (paddr == sys_setup_pkg::reg_addr(sys_setup_pkg::STATUS_INDEX)) begin
      hit_stat = 1'b1;
    end
  end

  always_comb begin
    read_value = 8'h00;
    if (hit_opt) begin
      read_value = options_reg;
    end else if (hit_cfg) begin
      read_value = setup_reg;
    end else if (hit_pull) begin
      read_value = {4'h0, pullup_reg};
    end else if (hit_stat) begin
      read_value = {port_pullup_en, 1'b0, ext_access_busy, loaded_reg, single_chip};
    end
  end

  assign setup_phase = psel && !penable;
  assign wr_commit   = psel && penable && pready && pwrite;

  // answer registered in setup, one wait-free access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase && !(hit_opt || hit_cfg || hit_pull || hit_wdog || hit_stat);
      if (setup_phase && !pwrite) begin
        prdata <= {24'h00_0000, read_value};
      end
    end
  end

  // options register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      options_reg <= sys_setup_pkg::OPTIONS_RESET;
    end else if (wr_commit && hit_opt) begin
      options_reg <= pwdata[7:0];
    end
  end

  // setup register: strap loaded once the synchroniser has settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_reg     <= sys_setup_pkg::CONFIG_RESET;
      load_wait_reg <= 2'h0;
      loaded_reg    <= 1'b0;
    end else begin
      if (!loaded_reg && load_wait_reg == 2'(sys_setup_pkg::SYNC_STAGES)) begin
        setup_reg  <= pin_s.setup_strap;
        loaded_reg <= 1'b1;
      end else if (wr_commit && hit_cfg) begin
        setup_reg <= pwdata[7:0];
      end
      if (!loaded_reg) begin
        load_wait_reg <= load_wait_reg + 2'h1;
      end
    end
  end

  // per-port pull-up enables, order b f g h from bit 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_reg <= sys_setup_pkg::PULLUP_RESET;
    end else if (wr_commit && hit_pull) begin
      pullup_reg <= pwdata[3:0];
    end
  end

  // pin-facing controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_strobe_pin_o    <= 1'b0;
      mode_strobe_pin_oe   <= 1'b0;
      portc_o              <= 8'h00;
      portc_oe             <= 8'h00;
      serial_low_bit_first <= 1'b0;
      spi_rate_select      <= 1'b0;
      port_pullup_en       <= 4'h0;
    end else begin
      mode_strobe_pin_o  <= load_instruction_strobe;
      mode_strobe_pin_oe <= options_reg[sys_setup_pkg::OPT_STROBE_DRIVE];
      portc_o            <= portc_data;
      // open drain only ever pulls low
      if (options_reg[sys_setup_pkg::OPT_PORTC_OD]) begin
        portc_oe <= portc_dir & ~portc_data;
      end else begin
        portc_oe <= portc_dir;
      end
      serial_low_bit_first <= options_reg[sys_setup_pkg::OPT_LOW_BIT];
      spi_rate_select      <= options_reg[sys_setup_pkg::OPT_SPI_RATE];
      port_pullup_en       <= pullup_reg & {4{setup_reg[sys_setup_pkg::CFG_PULLUP_MSTR]}};
    end
  end

  // external access sequencer
  always_comb begin
    ext_state_next = ext_state_reg;
    case (ext_state_reg)
      sys_setup_pkg::EXT_IDLE: begin
        if (ext_access_start) begin
          ext_state_next = sys_setup_pkg::EXT_FIRST;
        end
      end
      sys_setup_pkg::EXT_FIRST: begin
        ext_state_next = sys_setup_pkg::EXT_LAST;
      end
      sys_setup_pkg::EXT_LAST: begin
        if (options_reg[sys_setup_pkg::OPT_STRETCH]) begin
          ext_state_next = sys_setup_pkg::EXT_STRETCH;
        end else begin
          ext_state_next = sys_setup_pkg::EXT_IDLE;
        end
      end
      default: begin
        ext_state_next = sys_setup_pkg::EXT_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_state_reg   <= sys_setup_pkg::EXT_IDLE;
      ext_access_busy <= 1'b0;
    end else begin
      ext_state_reg   <= ext_state_next;
      ext_access_busy <= ext_state_next != sys_setup_pkg::EXT_IDLE;
    end
  end

  // external data bus and bus clock pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_data_o    <= 8'h00;
      ext_data_oe   <= 1'b0;
      bus_clock_pin <= 1'b0;
    end else begin
      ext_data_o  <= internal_read_data;
      ext_data_oe <= !single_chip && internal_read_valid
                     && options_reg[sys_setup_pkg::OPT_VISIBILITY];
      if (options_reg[sys_setup_pkg::OPT_BUS_CLK_DIS]) begin
        bus_clock_pin <= 1'b0;
      end else if (single_chip && options_reg[sys_setup_pkg::OPT_VISIBILITY]) begin
        bus_clock_pin <= 1'b0;
      end else begin
        bus_clock_pin <= pin_s.bus_clock;
      end
    end
  end

  // fast clock output; sampled copy, so limited to half the pclk rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_clock_pin <= 1'b0;
      fast_clock_oe  <= 1'b0;
    end else begin
      fast_clock_oe <= setup_reg[sys_setup_pkg::CFG_FAST_OUT_EN];
      if (!setup_reg[sys_setup_pkg::CFG_FAST_OUT_EN]) begin
        fast_clock_pin <= 1'b0;
      end else if (options_reg[sys_setup_pkg::OPT_FAST_SRC]) begin
        fast_clock_pin <= pin_s.oscillator_input_clock;
      end else begin
        fast_clock_pin <= pin_s.quadrupled_clock;
      end
    end
  end

  // memory map; low rom and freeze only make sense when expanded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      memory_map <= '0;
    end else begin
      memory_map.rom_high_map           <= setup_reg[sys_setup_pkg::CFG_ROM_HIGH] || single_chip;
      memory_map.bus_hold_when_internal <= setup_reg[sys_setup_pkg::CFG_BUS_HOLD] && !single_chip;
      memory_map.security_off           <= setup_reg[sys_setup_pkg::CFG_SECURITY_OFF];
      memory_map.rom_present            <= setup_reg[sys_setup_pkg::CFG_ROM_PRESENT];
      memory_map.eeprom_present         <= setup_reg[sys_setup_pkg::CFG_EEPROM_PRES];
    end
  end

  // watchdog: any write to the service register restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_count_reg     <= 24'h00_0000;
      watchdog_reset_req <= 1'b0;
    end else begin
      watchdog_reset_req <= 1'b0;
      if (setup_reg[sys_setup_pkg::CFG_WDOG_OFF] || (wr_commit && hit_wdog)) begin
        wdog_count_reg <= 24'h00_0000;
      end else if (wdog_count_reg == 24'(WDOG_CYCLES - 1)) begin
        wdog_count_reg     <= 24'h00_0000;
        watchdog_reset_req <= 1'b1;
      end else begin
        wdog_count_reg <= wdog_count_reg + 24'h00_0001;
      end
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence ext_begin_s;
    ext_access_start && ext_state_reg == sys_setup_pkg::EXT_IDLE;
  endsequence
  sequence ext_stretched_s;
    ext_access_busy [*3] ##1 !ext_access_busy;
  endsequence
  sequence ext_plain_s;
    ext_access_busy [*2] ##1 !ext_access_busy;
  endsequence

  strobe_drive_a: assert property (
    ##1 mode_strobe_pin_oe == $past(options_reg[sys_setup_pkg::OPT_STROBE_DRIVE]))
    else $error("strobe drive enable does not follow its bit");
  open_drain_a: assert property (
    options_reg[sys_setup_pkg::OPT_PORTC_OD] |=> (portc_oe & portc_o) == 8'h00)
    else $error("port c drives high in open drain mode");
  stretch_access_a: assert property (
    ext_state_reg == sys_setup_pkg::EXT_LAST |=> ext_access_busy == $past(options_reg[sys_setup_pkg::OPT_STRETCH]))
    else $error("stretch cycle does not follow the stretch bit");
  stretch_len_a: assert property (
    ext_begin_s ##0 options_reg[sys_setup_pkg::OPT_STRETCH] && !wr_commit ##1 !wr_commit |-> ext_stretched_s)
    else $error("stretched access is not three cycles");
  plain_len_a: assert property (
    ext_begin_s ##0 !options_reg[sys_setup_pkg::OPT_STRETCH] && !wr_commit ##1 !wr_commit |-> ext_plain_s)
    else $error("plain access is not two cycles");
  read_visible_a: assert property (
    ##1 ext_data_oe == $past(!single_chip && internal_read_valid && options_reg[sys_setup_pkg::OPT_VISIBILITY]))
    else $error("external data drive does not follow visibility");
  eclock_low_a: assert property (
    $past(options_reg[sys_setup_pkg::OPT_BUS_CLK_DIS])
      || $past(single_chip && options_reg[sys_setup_pkg::OPT_VISIBILITY]) |-> !bus_clock_pin)
    else $error("bus clock pin not held low");
  spi_order_a: assert property (
    ##1 serial_low_bit_first == $past(options_reg[sys_setup_pkg::OPT_LOW_BIT]))
    else $error("bit order output lags its bit");
  fast_clock_a: assert property (
    !setup_reg[sys_setup_pkg::CFG_FAST_OUT_EN] |=> !fast_clock_pin && !fast_clock_oe)
    else $error("fast clock pin active while disabled");
  pullup_gate_a: assert property (
    ##1 port_pullup_en == ($past(pullup_reg) & {4{$past(setup_reg[sys_setup_pkg::CFG_PULLUP_MSTR])}}))
    else $error("pull-up enables not gated by master enable");
  rom_map_a: assert property (
    single_chip && $stable(single_chip) |=> memory_map.rom_high_map && !memory_map.bus_hold_when_internal)
    else $error("single chip map has low rom or bus freeze");
  watchdog_off_a: assert property (
    setup_reg[sys_setup_pkg::CFG_WDOG_OFF] |=> !watchdog_reset_req)
    else $error("watchdog fired while disabled");
  readback_a: assert property (
    wr_commit && hit_opt |=> options_reg == $past(pwdata[7:0]))
    else $error("options register did not take written value");
endmodule

// *** verif/tb_system_config_registers.sv ***
// self-checking bench for the system configuration register bank
`timescale 1ns/1ps
module tb_system_config_registers;
  localparam int         WDOG_N = 64;
  localparam logic [11:0] OPT_A = {2'b00, sys_setup_pkg::OPTIONS_INDEX, 2'b00};
  localparam logic [11:0] CFG_A = {2'b00, sys_setup_pkg::CONFIGURATION_INDEX, 2'b00};
  localparam logic [11:0] PU_A  = {2'b00, sys_setup_pkg::PULLUP_INDEX, 2'b00};
  localparam logic [11:0] SVC_A = {2'b00, sys_setup_pkg::WDOG_SERVICE_INDEX, 2'b00};
  localparam logic [11:0] ST_A  = {2'b00, sys_setup_pkg::STATUS_INDEX, 2'b00};
  localparam logic [7:0]  STRAP = 8'hd6;
  logic                          pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]                   paddr;
  logic [31:0]                   pwdata, prdata, rd_data;
  logic                          rd_err, lis, xstart, irv, strobe_o, strobe_oe, busy, xd_oe, bclk;
  logic                          fclk, fclk_oe, lsb_first, spi_rate, wd_req;
  logic [7:0]                    pc_data, pc_dir, ird, pc_o, pc_oe, xd_o;
  logic [3:0]                    pu_en;
  sys_setup_pkg::pin_in_type     pin_in;
  sys_setup_pkg::memory_map_type mmap;
  int                            fails, compares, wd_pulses, n, w0;
  logic [7:0]                    ov [4] = '{8'hff, 8'h00, 8'h5a, 8'ha5};

  system_config_registers #(.WDOG_CYCLES(WDOG_N)) system_config_registers_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pin_in(pin_in), .load_instruction_strobe(lis), .portc_data(pc_data), .portc_dir(pc_dir),
    .ext_access_start(xstart), .internal_read_valid(irv), .internal_read_data(ird),
    .mode_strobe_pin_o(strobe_o), .mode_strobe_pin_oe(strobe_oe), .portc_o(pc_o), .portc_oe(pc_oe),
    .ext_access_busy(busy), .ext_data_o(xd_o), .ext_data_oe(xd_oe), .bus_clock_pin(bclk),
    .fast_clock_pin(fclk), .fast_clock_oe(fclk_oe), .serial_low_bit_first(lsb_first),
    .spi_rate_select(spi_rate), .port_pullup_en(pu_en), .memory_map(mmap), .watchdog_reset_req(wd_req));

  always #10 pclk = ~pclk;

  // counts watchdog pulses whatever the main sequence is doing
  always @(posedge pclk) begin
    if (wd_req === 1'b1) wd_pulses++;
  end

  task automatic results;
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // one apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      fails++;
      $display("ERROR at %0t: no pready", $time);
      results();
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string what);
    apb(a, 1'b0, 8'h00);
    chk(rd_data, {24'h0, exp}, what);
  endtask

  // settle time covers the two synchroniser edges plus the output register
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
    cyc(5);
  endtask

  task automatic ext_run(input logic [7:0] opt, input int exp);
    int cnt;
    cnt = 0;
    wr(OPT_A, opt);
    xstart <= 1'b1;
    cyc(2);
    xstart <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (busy === 1'b1) cnt++;
      cyc(1);
    end
    chk(cnt, exp, "busy length");
  endtask

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    lis = 0; xstart = 0; irv = 0; ird = 0; pc_data = 8'h3c; pc_dir = 8'hf0;
    pin_in = '{single_chip: 1'b0, bus_clock: 1'b1, oscillator_input_clock: 1'b1,
               quadrupled_clock: 1'b0, setup_strap: STRAP};
    fails = 0; compares = 0; wd_pulses = 0;
    cyc(12);
    presetn <= 1'b1;
    cyc(6);
    rd(OPT_A, 8'h00, "options reset");
    rd(CFG_A, STRAP, "setup loaded");
    rd(PU_A, 8'h0f, "pullup reset");
    rd(ST_A, 8'hf2, "status after load");
    chk(pu_en, 4'hf, "strap pullups on");
    chk(strobe_oe, 0, "strobe oe reset");
    apb(12'h004, 1'b0, 8'h00);
    chk(rd_err, 1, "unmapped error");
    chk(rd_data, 0, "unmapped data");
    apb(12'h004, 1'b1, 8'h77);
    chk(rd_err, 1, "unmapped write error");
    rd(OPT_A, 8'h00, "options after bad write");
    $display("test reset and map done");

    lis <= 1'b1;
    foreach (ov[i]) begin
      wr(OPT_A, ov[i]);
      rd(OPT_A, ov[i], "options readback");
      chk(strobe_oe, ov[i][7], "strobe oe");
      if (ov[i][7]) chk(strobe_o, 1, "strobe o");
      chk(pc_oe, ov[i][6] ? (pc_dir & ~pc_data) : pc_dir, "portc oe");
      chk(pc_o, pc_data, "portc data");
      chk(lsb_first, ov[i][3], "bit order");
      chk(spi_rate, ov[i][2], "spi rate");
    end
    $display("test options outputs done");

    ext_run(8'h00, 2);
    ext_run(8'h20, 3);
    $display("test stretch done");

    irv <= 1'b1;
    ird <= 8'h3c;
    wr(OPT_A, 8'h10);
    chk(xd_oe, 1, "visible oe");
    chk(xd_o, 8'h3c, "visible data");
    chk(bclk, 1, "expanded clock");
    wr(OPT_A, 8'h00);
    chk(xd_oe, 0, "invisible");
    wr(OPT_A, 8'h01);
    chk(bclk, 0, "clock disabled");
    pin_in.single_chip <= 1'b1;
    wr(OPT_A, 8'h00);
    chk(bclk, 1, "single chip clock");
    wr(OPT_A, 8'h10);
    chk(bclk, 0, "single chip held");
    $display("test bus clock done");

    wr(CFG_A, 8'h24);
    wr(OPT_A, 8'h02);
    chk(fclk_oe, 1, "fast oe on");
    chk(fclk, 1, "oscillator sel");
    wr(OPT_A, 8'h00);
    chk(fclk, 0, "quadrupled sel");
    wr(CFG_A, 8'h04);
    chk(fclk_oe, 0, "fast oe off");
    $display("test fast clock done");

    wr(PU_A, 8'h0a);
    rd(PU_A, 8'h0a, "pullup readback");
    wr(CFG_A, 8'h14);
    chk(pu_en, 4'ha, "pullups on");
    wr(CFG_A, 8'h04);
    chk(pu_en, 4'h0, "pullups off");
    chk(mmap, 5'b10000, "single chip map");
    wr(CFG_A, 8'h44);
    chk(mmap, 5'b10000, "no freeze single");
    pin_in.single_chip <= 1'b0;
    wr(CFG_A, 8'hcf);
    rd(CFG_A, 8'hcf, "setup readback");
    chk(mmap, 5'b11111, "map all set");
    wr(CFG_A, 8'h04);
    chk(mmap, 5'b00000, "map all clear");
    wr(CFG_A, 8'h0b);
    chk(mmap, 5'b00111, "security rom eeprom");
    wr(CFG_A, 8'h05);
    chk(mmap, 5'b00001, "eeprom only");
    $display("test setup register done");

    w0 = wd_pulses;
    wr(CFG_A, 8'h00);
    n = 0;
    while (wd_pulses == w0 && n < 200) begin
      cyc(1);
      n++;
    end
    chk(n >= WDOG_N - 8 && n <= WDOG_N + 4, 1, "watchdog period");
    w0 = wd_pulses;
    for (int i = 0; i < 5; i++) begin
      apb(SVC_A, 1'b1, 8'h55);
      cyc(WDOG_N / 2);
    end
    chk(wd_pulses, w0, "serviced watchdog");
    wr(CFG_A, 8'h04);
    w0 = wd_pulses;
    cyc(2 * WDOG_N + 10);
    chk(wd_pulses, w0, "watchdog off");
    $display("test watchdog done");
    results();
  end
endmodule
